/* src/ivu_pkg.sv */
// Constants, state codes and helpers shared by the interrupt vector/enable unit.
// Assumes a single core clock domain and special-function byte addressing.
`default_nettype none

package ivu_pkg;

	// ************************************************************
	// Special-function register addresses
	// ************************************************************
	localparam logic [7:0] STD_EN_ADDR       = 8'hc0;
	localparam logic [7:0] STD_PRIO_ADDR     = 8'hc1;
	localparam logic [7:0] EXT_EN_ONE_ADDR   = 8'he6;
	localparam logic [7:0] EXT_PRIO_ONE_ADDR = 8'hce;
	localparam logic [7:0] EXT_EN_TWO_ADDR   = 8'he7;
	localparam logic [7:0] EXT_PRIO_TWO_ADDR = 8'hcf;
	localparam logic [7:0] REG_RESET         = 8'h00;
	localparam logic [7:0] READ_UNMAPPED     = 8'h00;

	// ************************************************************
	// Field positions and source orders
	// ************************************************************
	localparam int          NUM_SRC        = 17;
	localparam int          ORDER_W        = 5;
	localparam int          STD_GLOBAL_BIT = 7;
	localparam int          NUM_AUTO_CLEAR = 4;
	localparam int          PCA_MODULES    = 3;
	localparam logic [4:0]  ORD_RESERVED   = 5'h0d;
	localparam logic [16:0] RESERVED_MASK  = 17'h02000;

	// ************************************************************
	// Vector layout
	// ************************************************************
	localparam logic [15:0] RESET_VECTOR = 16'h0000;
	localparam logic [15:0] VECTOR_BASE  = 16'h0003;

	// Nesting levels of the running handler
	typedef enum logic [1:0] {
		ST_IDLE          = 2'b00,
		ST_LOW           = 2'b01,
		ST_HIGH          = 2'b10,
		ST_HIGH_OVER_LOW = 2'b11
	} ivu_nest_type;

	// Code address of a maskable source: base plus eight per order step
	function automatic logic [15:0] ivu_vector_of(input logic [4:0] order);
		return VECTOR_BASE + {8'h00, order, 3'h0};
	endfunction

endpackage

`default_nettype wire

/* src/ivu_link_if.sv */
// Carrier between the unit's control file, the source gate and the arbiter.
// Assumes all three sit on the same core clock; the signals are combinational.
`timescale 1ns/10ps
`default_nettype none

interface ivu_link_if;
	logic [16:0] src_any;
	logic [16:0] enable_bits;
	logic [16:0] prio_bits;
	logic [16:0] req_raw;
	logic        allow_low;
	logic        allow_high;
	logic        win_valid;
	logic [4:0]  win_order;
	logic        win_high;

	modport gate (input src_any, input enable_bits, output req_raw);
	modport arb  (input req_raw, input prio_bits, input allow_low, input allow_high,
		output win_valid, output win_order, output win_high);
	modport ctrl (output src_any, output enable_bits, output prio_bits, output allow_low,
		output allow_high, input req_raw, input win_valid, input win_order, input win_high);
endinterface

`default_nettype wire

/* src/ivu_source_gate.sv */
// Enable gating of the seventeen per-order source requests.
// Assumes src_any already ORs every flag that shares a vector.
`timescale 1ns/10ps
`default_nettype none

module ivu_source_gate (
	// Link to the control file
	ivu_link_if.gate link
);

	// ************************************************************
	// Gating
	// ************************************************************
	// The reserved order never requests, even if its stored bit is set
	always_comb begin
		link.req_raw = link.src_any & link.enable_bits & ~ivu_pkg::RESERVED_MASK; // see RULE_02
	end

endmodule

`default_nettype wire

/* src/ivu_arbiter.sv */
// Fixed-order, two-level pick of the next request to present to the core.
// Assumes allow_low and allow_high already reflect the running handler level.
`timescale 1ns/10ps
`default_nettype none

module ivu_arbiter (
	// Link to the control file
	ivu_link_if.arb link
);

	logic [16:0] hi_req;
	logic [16:0] lo_req;
	logic [16:0] pick;

	// ************************************************************
	// Selection
	// ************************************************************
	// High level first, then lowest order number wins within the level
	always_comb begin
		hi_req = link.req_raw & link.prio_bits & {17{link.allow_high}}; // see RULE_21
		lo_req = link.req_raw & ~link.prio_bits & {17{link.allow_low}};
		pick = (|hi_req) ? hi_req : lo_req;
		link.win_high = |hi_req; // see RULE_20
		link.win_valid = |pick;
		link.win_order = 5'h00;
		for (int i = ivu_pkg::NUM_SRC - 1; i >= 0; i--) begin
			if (pick[i]) begin
				link.win_order = 5'(i);
			end
		end
	end

endmodule

`default_nettype wire

/* src/ivu_unit.sv */
// Interrupt vector and enable unit: enable/priority registers, nesting and vector hand-off.
// Assumes peripheral flags and the special-function port are on the core clock.
`timescale 1ns/10ps
`default_nettype none

// How it works
// RULE_01: Reset clears everything, drops any request and is never masked.
// RULE_02: Each maskable order vectors to 0x0003 plus eight times order; 13 unused.
// RULE_03: Order numbers are fixed per source from external 0 up to capsense compare 16.
// RULE_04: External pin and timer 0/1 flags get a clear pulse on vectoring.
// RULE_05: Serial receive and transmit flags share one request, software clears.
// RULE_06: Timer 2 high and low overflow share one request, software clears.
// RULE_07: Four SPI flags share one request at one vector.
// RULE_08: Port match has no flag; its request follows the condition and enable.
// RULE_09: Counter overflow and every module match share one vector, not cleared.
// RULE_10: Comparator rise and fall flags share one vector, not cleared.
// RULE_11: Capsense done and compare use orders 15 and 16, enabled by second register.
// RULE_12: Orders 0-6 use standard registers bits 0-6; orders 7-14 extended bits.
// RULE_13: First extended enable sits at 0xe6, read/write, resets to zero.
// RULE_14: Enable bits: two-wire 0, match 1, window 2, done 3, counter 4, comparator 5, timer3 7.
// RULE_15: Software writes zero to reserved bit 6 of that register.
// RULE_16: Timer 3 enable passes either timer 3 overflow flag, else masks both.
// RULE_17: Comparator enable passes either edge flag, else masks both.
// RULE_18: Clearing counter, match or two-wire enables masks all their requests.
// RULE_19: Window and conversion enables gate the converter window and done flags.
// RULE_20: A priority bit at zero means low level, one means high; resets low.
// RULE_21: High before low, lowest order within a level; high may preempt low.
module ivu_unit (
	// Clock, reset and freeze
	input  wire logic        clock,
	input  wire logic        sys_rst,
	input  wire logic        clk_en,
	// Special-function register port
	input  wire logic [7:0]  sfr_addr,
	input  wire logic [7:0]  sfr_wdata,
	input  wire logic        sfr_write,
	input  wire logic        sfr_read,
	output logic      [7:0]  sfr_rdata,
	// Core vectoring handshake
	output logic             irq_request,
	output logic      [15:0] irq_vector,
	output logic      [4:0]  irq_order,
	output logic             irq_high,
	input  wire logic        vector_ack,
	input  wire logic        handler_return,
	// Hardware clear pulses for orders 0 to 3
	output logic      [3:0]  hw_clear,
	// Peripheral flags
	input  wire logic        ext_pin0_pending,
	input  wire logic        timer0_overflow_flag,
	input  wire logic        ext_pin1_pending,
	input  wire logic        timer1_overflow_flag,
	input  wire logic        serial_receive_done,
	input  wire logic        serial_transmit_done,
	input  wire logic        timer2_high_overflow,
	input  wire logic        timer2_low_overflow,
	input  wire logic        spi_transfer_done,
	input  wire logic        spi_write_collision,
	input  wire logic        spi_mode_fault,
	input  wire logic        spi_receive_overrun,
	input  wire logic        twowire_flag,
	input  wire logic        port_match_active,
	input  wire logic        converter_window_flag,
	input  wire logic        converter_done_flag,
	input  wire logic        counter_array_overflow,
	input  wire logic [2:0]  counter_module_match,
	input  wire logic        comparator_fall_flag,
	input  wire logic        comparator_rise_flag,
	input  wire logic        timer3_high_overflow,
	input  wire logic        timer3_low_overflow,
	input  wire logic        capsense_done_flag,
	input  wire logic        capsense_compare_flag
);

	ivu_link_if link ();

	logic [7:0]           standard_irq_enable_reg;
	logic [7:0]           standard_irq_priority_reg;
	logic [7:0]           extended_irq_enable_one_reg;
	logic [7:0]           extended_irq_priority_one_reg;
	logic [7:0]           extended_irq_enable_two_reg;
	logic [7:0]           extended_irq_priority_two_reg;
	logic [7:0]           sfr_rdata_reg;
	logic [7:0]           sfr_rdata_next;
	ivu_pkg::ivu_nest_type nest_reg;
	ivu_pkg::ivu_nest_type nest_next;
	logic                 irq_request_reg;
	logic [15:0]          irq_vector_reg;
	logic [4:0]           irq_order_reg;
	logic                 irq_high_reg;
	logic [3:0]           hw_clear_reg;
	logic [3:0]           hw_clear_next;
	logic                 global_enable;
	logic                 ack_taken;

	// ************************************************************
	// Sub-blocks
	// ************************************************************
	ivu_source_gate u_gate (
		.link (link)
	);

	ivu_arbiter u_arb (
		.link (link)
	);

	// ************************************************************
	// Source collection
	// ************************************************************
	// Shared flags are ORed so that any one of them raises the order's request
	always_comb begin
		link.src_any = {
			capsense_compare_flag,                            // see RULE_11
			capsense_done_flag,
			timer3_high_overflow | timer3_low_overflow,       // see RULE_16
			1'b0,
			comparator_rise_flag | comparator_fall_flag,      // see RULE_10
			counter_array_overflow | (|counter_module_match), // see RULE_09
			converter_done_flag,                              // see RULE_19
			converter_window_flag,
			port_match_active,                                // see RULE_08
			twowire_flag,
			spi_transfer_done | spi_write_collision | spi_mode_fault | spi_receive_overrun, // see RULE_07
			timer2_high_overflow | timer2_low_overflow,       // see RULE_06
			serial_receive_done | serial_transmit_done,       // see RULE_05
			timer1_overflow_flag,                             // see RULE_03
			ext_pin1_pending,
			timer0_overflow_flag,
			ext_pin0_pending
		};
	end

	// Register bits laid out in order number, standard bits first
	always_comb begin
		link.enable_bits = {extended_irq_enable_two_reg[1:0], extended_irq_enable_one_reg,
			standard_irq_enable_reg[6:0]}; // see RULE_12, see RULE_14, see RULE_18
		link.prio_bits = {extended_irq_priority_two_reg[1:0], extended_irq_priority_one_reg,
			standard_irq_priority_reg[6:0]}; // see RULE_12
	end

	// Only a level above the running handler may be presented
	always_comb begin
		global_enable = standard_irq_enable_reg[ivu_pkg::STD_GLOBAL_BIT];
		link.allow_low = global_enable && (nest_reg == ivu_pkg::ST_IDLE);
		link.allow_high = global_enable && ((nest_reg == ivu_pkg::ST_IDLE) || (nest_reg == ivu_pkg::ST_LOW)); // see RULE_21
	end

	// ************************************************************
	// Register file
	// ************************************************************
	// Writes store the whole byte; the reserved bit is kept but never requests
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			standard_irq_enable_reg <= ivu_pkg::REG_RESET;
			standard_irq_priority_reg <= ivu_pkg::REG_RESET;
			extended_irq_enable_one_reg <= ivu_pkg::REG_RESET; // see RULE_13
			extended_irq_priority_one_reg <= ivu_pkg::REG_RESET; // see RULE_20
			extended_irq_enable_two_reg <= ivu_pkg::REG_RESET;
			extended_irq_priority_two_reg <= ivu_pkg::REG_RESET;
		end else if (clk_en && sfr_write) begin
			case (sfr_addr)
				ivu_pkg::STD_EN_ADDR:       standard_irq_enable_reg <= sfr_wdata;
				ivu_pkg::STD_PRIO_ADDR:     standard_irq_priority_reg <= sfr_wdata;
				ivu_pkg::EXT_EN_ONE_ADDR:   extended_irq_enable_one_reg <= sfr_wdata; // see RULE_13
				ivu_pkg::EXT_PRIO_ONE_ADDR: extended_irq_priority_one_reg <= sfr_wdata;
				ivu_pkg::EXT_EN_TWO_ADDR:   extended_irq_enable_two_reg <= sfr_wdata;
				ivu_pkg::EXT_PRIO_TWO_ADDR: extended_irq_priority_two_reg <= sfr_wdata;
				default: ;
			endcase
		end
	end

	// Read mux; unmapped addresses read as zero
	always_comb begin
		case (sfr_addr)
			ivu_pkg::STD_EN_ADDR:       sfr_rdata_next = standard_irq_enable_reg;
			ivu_pkg::STD_PRIO_ADDR:     sfr_rdata_next = standard_irq_priority_reg;
			ivu_pkg::EXT_EN_ONE_ADDR:   sfr_rdata_next = extended_irq_enable_one_reg;
			ivu_pkg::EXT_PRIO_ONE_ADDR: sfr_rdata_next = extended_irq_priority_one_reg;
			ivu_pkg::EXT_EN_TWO_ADDR:   sfr_rdata_next = extended_irq_enable_two_reg;
			ivu_pkg::EXT_PRIO_TWO_ADDR: sfr_rdata_next = extended_irq_priority_two_reg;
			default:                    sfr_rdata_next = ivu_pkg::READ_UNMAPPED;
		endcase
	end

	// Read data is held until the next read
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			sfr_rdata_reg <= ivu_pkg::REG_RESET;
		end else if (clk_en && sfr_read) begin
			sfr_rdata_reg <= sfr_rdata_next;
		end
	end

	// ************************************************************
	// Nesting state
	// ************************************************************
	assign ack_taken = vector_ack && irq_request_reg;

	// A taken high request over a low handler nests; return unwinds one level
	always_comb begin
		nest_next = nest_reg;
		case (nest_reg)
			ivu_pkg::ST_IDLE: begin
				if (ack_taken) begin
					nest_next = irq_high_reg ? ivu_pkg::ST_HIGH : ivu_pkg::ST_LOW;
				end
			end
			ivu_pkg::ST_LOW: begin
				if (ack_taken && irq_high_reg) begin
					nest_next = ivu_pkg::ST_HIGH_OVER_LOW; // see RULE_21
				end else if (handler_return) begin
					nest_next = ivu_pkg::ST_IDLE;
				end
			end
			ivu_pkg::ST_HIGH: begin
				if (handler_return) begin
					nest_next = ivu_pkg::ST_IDLE;
				end
			end
			ivu_pkg::ST_HIGH_OVER_LOW: begin
				if (handler_return) begin
					nest_next = ivu_pkg::ST_LOW;
				end
			end
			default: nest_next = ivu_pkg::ST_IDLE;
		endcase
	end

	always_ff @(posedge clock) begin
		if (sys_rst) begin
			nest_reg <= ivu_pkg::ST_IDLE; // see RULE_01
		end else if (clk_en) begin
			nest_reg <= nest_next;
		end
	end

	// ************************************************************
	// Request and vector to the core
	// ************************************************************
	// The request is dropped in the cycle it is taken so the core never sees a stale repeat
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			irq_request_reg <= 1'b0; // see RULE_01
			irq_vector_reg <= ivu_pkg::RESET_VECTOR;
			irq_order_reg <= 5'h00;
			irq_high_reg <= 1'b0;
		end else if (clk_en) begin
			irq_request_reg <= link.win_valid && !ack_taken;
			irq_vector_reg <= ivu_pkg::ivu_vector_of(link.win_order); // see RULE_02
			irq_order_reg <= link.win_order;
			irq_high_reg <= link.win_high;
		end
	end

	// Only the four lowest orders have flags that hardware clears on vectoring
	always_comb begin
		hw_clear_next = 4'h0;
		if (ack_taken && (irq_order_reg < 5'(ivu_pkg::NUM_AUTO_CLEAR))) begin
			hw_clear_next = 4'h1 << irq_order_reg[1:0]; // see RULE_04
		end
	end

	// One-cycle clear pulse; other flags are left for software
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			hw_clear_reg <= 4'h0;
		end else if (clk_en) begin
			hw_clear_reg <= hw_clear_next; // see RULE_05, see RULE_06, see RULE_09
		end
	end

	assign sfr_rdata = sfr_rdata_reg;
	assign irq_request = irq_request_reg;
	assign irq_vector = irq_vector_reg;
	assign irq_order = irq_order_reg;
	assign irq_high = irq_high_reg;
	assign hw_clear = hw_clear_reg;

	// ************************************************************
	// Assertions
	// ************************************************************
	default clocking cb @(posedge clock); endclocking
	default disable iff (sys_rst);

	a_reset_clears_regs: assert property (@(posedge clock) disable iff (1'b0)
		sys_rst |=> (extended_irq_enable_one_reg == 8'h00) && (extended_irq_priority_one_reg == 8'h00)
		&& !irq_request_reg && (nest_reg == ivu_pkg::ST_IDLE)) // see RULE_13
		else $error("reset did not clear registers and request");

	a_vector_matches_order: assert property (irq_request_reg |->
		irq_vector_reg == 16'h0003 + {8'h00, irq_order_reg, 3'h0}) // see RULE_02
		else $error("vector does not match order");

	a_reserved_never: assert property (irq_request_reg |-> irq_order_reg != 5'h0d) // see RULE_02
		else $error("reserved order presented");

	a_auto_clear_pulse: assert property (clk_en && ack_taken && irq_order_reg < 5'h04 |=>
		hw_clear_reg == (4'h1 << $past(irq_order_reg[1:0])) ##1 (!$past(clk_en) || hw_clear_reg == 4'h0)) // see RULE_04
		else $error("missing or long hardware clear pulse");

	a_no_clear_shared: assert property (clk_en && ack_taken && irq_order_reg >= 5'h04 |=> hw_clear_reg == 4'h0) // see RULE_05
		else $error("software-cleared flag got a hardware clear");

	a_timer3_gate: assert property ((timer3_low_overflow || timer3_high_overflow) |->
		link.req_raw[14] == extended_irq_enable_one_reg[7]) // see RULE_16
		else $error("timer 3 enable gating wrong");

	a_comparator_gate: assert property ((comparator_rise_flag || comparator_fall_flag) |->
		link.req_raw[12] == extended_irq_enable_one_reg[5]) // see RULE_17
		else $error("comparator enable gating wrong");

	a_port_match_direct: assert property (link.req_raw[8] == (port_match_active && extended_irq_enable_one_reg[1])) // see RULE_08
		else $error("port match request does not follow condition");

	a_high_over_low: assert property (nest_reg == ivu_pkg::ST_LOW && link.win_valid |-> link.win_high) // see RULE_21
		else $error("low request presented during low handler");

	a_high_blocks_all: assert property (clk_en && nest_reg[1] |=> !irq_request_reg) // see RULE_21
		else $error("request presented during high handler");

	// The winner must be an enabled, flagged source at the level its priority bit selects
	a_winner_enabled: assert property (link.win_valid |-> // see RULE_18
		link.enable_bits[link.win_order] && link.src_any[link.win_order] && (link.win_order != 5'h0d))
		else $error("winner is not an enabled source");

	a_winner_level: assert property (link.win_valid |-> link.win_high == link.prio_bits[link.win_order]) // see RULE_20
		else $error("winner level does not follow its priority bit");

	a_rdata_held: assert property (!sfr_read |=> $stable(sfr_rdata_reg)) // see RULE_13
		else $error("read data changed without a read");

	a_clear_needs_ack: assert property (clk_en && !ack_taken |=> hw_clear_reg == 4'h0) // see RULE_04
		else $error("hardware clear without a taken vector");

	c_preempt: cover property (nest_reg == ivu_pkg::ST_LOW ##1 nest_reg == ivu_pkg::ST_HIGH_OVER_LOW);
	c_last_vector: cover property (irq_request_reg && irq_vector_reg == 16'h0083);
	c_auto_clear: cover property (hw_clear_reg != 4'h0);
	c_unwind: cover property (nest_reg == ivu_pkg::ST_HIGH_OVER_LOW ##1 nest_reg == ivu_pkg::ST_LOW);

endmodule

`default_nettype wire

/* verification/ivu_core_model.sv */
// Partner model: the peripheral flag sources and the core's vectoring side.
// Assumes the unit's core clock; every output changes just after a rising edge.
`timescale 1ns/10ps
`default_nettype none

module ivu_core_model (
	// Clock and reset
	input  wire logic        clock,
	input  wire logic        sys_rst,
	// Bench commands
	input  wire logic [25:0] set_mask,
	input  wire logic [25:0] clr_mask,
	input  wire logic        ack_go,
	input  wire logic        ret_go,
	// Unit side
	input  wire logic        irq_request,
	input  wire logic [3:0]  hw_clear,
	output logic      [25:0] flags          = 26'h0,
	output logic             vector_ack     = 1'b0,
	output logic             handler_return = 1'b0
);
	logic       armed;
	logic [1:0] wait_cnt;

	// Flags are sticky; only software or a clear pulse of orders 0 to 3 drops them
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			flags <= 26'h0;
		end else begin
			flags <= (flags | set_mask) & ~clr_mask & ~{22'h0, hw_clear};
		end
	end

	// Core takes the vector after a random stall, only while a request stands
	always_ff @(posedge clock) begin
		if (sys_rst) begin
			armed <= 1'b0;
			wait_cnt <= 2'h0;
			vector_ack <= 1'b0;
		end else begin
			vector_ack <= 1'b0;
			if (ack_go) begin
				armed <= 1'b1;
				wait_cnt <= 2'($urandom_range(3));
			end else if (armed && irq_request) begin
				if (wait_cnt == 2'h0) begin
					armed <= 1'b0;
					vector_ack <= 1'b1;
				end else begin
					wait_cnt <= wait_cnt - 2'h1;
				end
			end
		end
	end

	// Return from interrupt is a single pulse on command
	always_ff @(posedge clock) begin
		handler_return <= sys_rst ? 1'b0 : ret_go;
	end
endmodule

`default_nettype wire

/* verification/testbench.sv */
// Self-checking bench: unit, partner model and an integer model of the arbitration.
// Assumes the unit's special-function port and a 10 MHz core clock.
`timescale 1ns/10ps
`default_nettype none

module testbench;
	`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; $display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
	logic        clock     = 1'b0;
	logic        sys_rst   = 1'b1;
	logic        clk_en    = 1'b1;
	logic        sfr_write = 1'b0;
	logic        sfr_read  = 1'b0;
	logic        ack_go    = 1'b0;
	logic        ret_go    = 1'b0;
	logic [7:0]  sfr_addr  = 8'h00;
	logic [7:0]  sfr_wdata = 8'h00;
	logic [25:0] set_mask  = 26'h0;
	logic [25:0] clr_mask  = 26'h0;
	logic [7:0]  sfr_rdata;
	logic [15:0] irq_vector;
	logic [4:0]  irq_order;
	logic [3:0]  hw_clear;
	logic [25:0] fl;
	logic        irq_request, irq_high, vector_ack, handler_return;
	int          err_total = 0, check_count = 0, cycles = 0, w;
	int          mir [6];
	int          fq [$];
	// Order of each flag bit; flags that share a vector share an order
	int          ord_tab [26] = '{0, 1, 2, 3, 4, 4, 5, 5, 6, 6, 6, 6, 7, 8, 9, 10, 11, 11, 11, 11, 12, 12, 14, 14, 15, 16};
	logic [7:0]  adr [6] = '{ivu_pkg::STD_EN_ADDR, ivu_pkg::STD_PRIO_ADDR, ivu_pkg::EXT_EN_ONE_ADDR,
		ivu_pkg::EXT_PRIO_ONE_ADDR, ivu_pkg::EXT_EN_TWO_ADDR, ivu_pkg::EXT_PRIO_TWO_ADDR};

	ivu_unit ivu_unit_inst (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en), .sfr_addr(sfr_addr),
		.sfr_wdata(sfr_wdata), .sfr_write(sfr_write), .sfr_read(sfr_read), .sfr_rdata(sfr_rdata),
		.irq_request(irq_request), .irq_vector(irq_vector), .irq_order(irq_order), .irq_high(irq_high),
		.vector_ack(vector_ack), .handler_return(handler_return), .hw_clear(hw_clear),
		.ext_pin0_pending(fl[0]), .timer0_overflow_flag(fl[1]), .ext_pin1_pending(fl[2]),
		.timer1_overflow_flag(fl[3]), .serial_receive_done(fl[4]), .serial_transmit_done(fl[5]),
		.timer2_high_overflow(fl[6]), .timer2_low_overflow(fl[7]), .spi_transfer_done(fl[8]),
		.spi_write_collision(fl[9]), .spi_mode_fault(fl[10]), .spi_receive_overrun(fl[11]),
		.twowire_flag(fl[12]), .port_match_active(fl[13]), .converter_window_flag(fl[14]),
		.converter_done_flag(fl[15]), .counter_array_overflow(fl[16]), .counter_module_match(fl[19:17]),
		.comparator_fall_flag(fl[20]), .comparator_rise_flag(fl[21]), .timer3_high_overflow(fl[22]),
		.timer3_low_overflow(fl[23]), .capsense_done_flag(fl[24]), .capsense_compare_flag(fl[25]));

	ivu_core_model ivu_core_model_inst (.clock(clock), .sys_rst(sys_rst), .set_mask(set_mask),
		.clr_mask(clr_mask), .ack_go(ack_go), .ret_go(ret_go), .irq_request(irq_request),
		.hw_clear(hw_clear), .flags(fl), .vector_ack(vector_ack), .handler_return(handler_return));

	// ********************************
	// Reference model
	// ********************************
	// Enable (r=0) or priority (r=1) bit of an order; order 13 maps to a bit no source uses
	function automatic int bit_of(input int r, input int o);
		if (o < 7) return (mir[r] >> o) & 1;
		if (o < 15) return (mir[r + 2] >> (o - 7)) & 1;
		return (mir[r + 4] >> (o - 15)) & 1;
	endfunction

	// High level first, then lowest order; result is order plus 32 for high, or -1
	function automatic int exp_win(input logic [25:0] f, input int lvl_min);
		if (((mir[0] >> 7) & 1) == 0) return -1;
		for (int l = 1; l >= lvl_min; l--) begin
			for (int i = 0; i < 26; i++) begin
				if (f[i] && bit_of(0, ord_tab[i]) == 1 && bit_of(1, ord_tab[i]) == l) return ord_tab[i] + 32 * l;
			end
		end
		return -1;
	endfunction

	// ********************************
	// Bus and handshake tasks
	// ********************************
	task automatic wr(input logic [7:0] a, input logic [7:0] v);
		@(posedge clock);
		sfr_addr <= a;
		sfr_wdata <= v;
		sfr_write <= 1'b1;
		@(posedge clock);
		sfr_write <= 1'b0;
	endtask

	// Read data lands on the edge after the strobe edge, so sample at the next falling edge
	task automatic rd(input logic [7:0] a, output logic [7:0] v);
		@(posedge clock);
		sfr_addr <= a;
		sfr_read <= 1'b1;
		@(posedge clock);
		sfr_read <= 1'b0;
		@(negedge clock);
		v = sfr_rdata;
	endtask

	// Six registers packed low byte first: enable, priority, ext one pair, ext two pair
	task automatic cfg(input logic [47:0] v);
		for (int i = 0; i < 6; i++) begin
			mir[i] = int'(v[8 * i +: 8]);
			wr(adr[i], v[8 * i +: 8]);
		end
	endtask

	// Flags are replaced whole; the request lags them by a registered stage
	task automatic setf(input logic [25:0] v);
		@(posedge clock);
		set_mask <= v;
		clr_mask <= ~v;
		@(posedge clock);
		set_mask <= 26'h0;
		clr_mask <= 26'h0;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic chk_req(input logic [25:0] f, input int lvl_min);
		w = exp_win(f, lvl_min);
		`CHK(irq_request, 1'(w >= 0))
		if (w >= 0) begin
			`CHK(irq_order, 5'(w))
			`CHK(irq_vector, 16'(3 + 8 * (w % 32)))
			`CHK(irq_high, 1'(w / 32))
		end
	endtask

	task automatic serve(input logic [3:0] clr);
		int n;
		n = 0;
		@(posedge clock);
		ack_go <= 1'b1;
		@(posedge clock);
		ack_go <= 1'b0;
		while (vector_ack !== 1'b1 && n < 20) begin
			@(negedge clock);
			n++;
		end
		`CHK(vector_ack, 1'b1)
		@(negedge clock);
		`CHK(hw_clear, clr)
		`CHK(irq_request, 1'b0)
	endtask

	// Return pulse from the core, then let the request settle before looking
	task automatic ret;
		@(posedge clock);
		ret_go <= 1'b1;
		@(posedge clock);
		ret_go <= 1'b0;
		repeat (3) @(posedge clock);
		@(negedge clock);
	endtask

	task automatic summarize;
		$display("Comparisons %0d, mismatches %0d", check_count, err_total);
		if (err_total == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	// Free-running 100 ns clock
	initial forever #50 clock = ~clock;

	// Hang guard, far above the fewer than one thousand cycles the sequence needs
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_total++;
			summarize();
		end
	end

	// ********************************
	// Main sequence
	// ********************************
	initial begin
		logic [7:0]  v;
		logic [25:0] r;
		void'($urandom(26));
		repeat (20) @(posedge clock);
		sys_rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			rd(adr[i], v);
			`CHK(v, 8'h00)
		end
		rd(8'h5a, v);
		`CHK(v, 8'h00)
		for (int i = 0; i < 4; i++) begin
			r = 26'($urandom) & 26'h00000bf;
			wr(ivu_pkg::EXT_EN_ONE_ADDR, r[7:0]);
			rd(ivu_pkg::EXT_EN_ONE_ADDR, v);
			`CHK(v, r[7:0])
		end
		// A frozen clock enable must drop the write
		@(posedge clock);
		clk_en <= 1'b0;
		wr(ivu_pkg::EXT_EN_ONE_ADDR, ~r[7:0] & 8'hbf);
		@(posedge clock);
		clk_en <= 1'b1;
		rd(ivu_pkg::EXT_EN_ONE_ADDR, v);
		`CHK(v, r[7:0])
		// Each flag alone, everything enabled at low level, reserved bit kept zero
		cfg(48'h0003_00bf_00ff);
		for (int i = 0; i < 26; i++) begin
			setf(26'h1 << i);
			chk_req(26'h1 << i, 0);
		end
		cfg(48'h0000_0000_0080);
		setf(26'h3ffffff);
		chk_req(26'h3ffffff, 0);
		cfg(48'h0003_00bf_007f);
		@(negedge clock);
		chk_req(26'h3ffffff, 0);
		// Random enables, priorities and flags against the model
		repeat (30) fq.push_back($urandom);
		while (fq.size() > 0) begin
			r = 26'(fq.pop_front());
			cfg(48'({$urandom, $urandom}) & 48'hff03_ffbf_ffff);
			setf(r);
			chk_req(r, 0);
		end
		// Vectoring: pin flag cleared by hardware, serial flag left for software
		cfg(48'h0000_0000_0091);
		setf(26'h11);
		chk_req(26'h11, 0);
		serve(4'h1);
		repeat (3) @(negedge clock);
		`CHK(fl[0], 1'b0)
		`CHK(irq_request, 1'b0)
		ret();
		chk_req(26'h10, 0);
		serve(4'h0);
		`CHK(fl[4], 1'b1)
		// A high-level pin request preempts the running low handler
		cfg(48'h0000_0000_0191);
		setf(26'h11);
		chk_req(26'h11, 1);
		serve(4'h1);
		// Returns unwind high then low; the pending low serial request comes back last
		ret();
		`CHK(irq_request, 1'b0)
		ret();
		chk_req(26'h10, 0);
		summarize();
	end
endmodule

`default_nettype wire
